// ---- io_map_pkg.sv ----
package io_map_pkg;
    localparam int NUM_DI = 8;
    localparam int NUM_DO = 4;
    localparam int NUM_GEAR = 4;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int SEL_W = 8;
    localparam int SPD_W = 16;

    // input function codes
    localparam logic [SEL_W-1:0] FN_DISABLED = 8'h00;
    localparam logic [SEL_W-1:0] FN_JOG_FWD = 8'h37;
    localparam logic [SEL_W-1:0] FN_JOG_REV = 8'h38;
    localparam logic [SEL_W-1:0] FN_GEAR_SEL0 = 8'h43;
    localparam logic [SEL_W-1:0] FN_GEAR_SEL1 = 8'h44;
    localparam logic [SEL_W-1:0] FN_INHIBIT = 8'h45;
    localparam logic [SEL_W-1:0] FN_STOP = 8'h46;

    // output function codes
    localparam logic [SEL_W-1:0] FO_READY = 8'h01;
    localparam logic [SEL_W-1:0] FO_POWER = 8'h02;
    localparam logic [SEL_W-1:0] FO_ZERO_SPD = 8'h03;
    localparam logic [SEL_W-1:0] FO_TARGET_SPD = 8'h04;

    // control mode values
    localparam logic [SEL_W-1:0] MODE_SINGLE_LO = 8'h0b;
    localparam logic [SEL_W-1:0] MODE_SINGLE_HI = 8'h11;
    localparam logic [SEL_W-1:0] MODE_DUAL_LO = 8'h12;
    localparam logic [SEL_W-1:0] MODE_DUAL_HI = 8'h14;
    localparam logic [SEL_W-1:0] MODE_PT = 8'h0b;
    localparam logic [SEL_W-1:0] MODE_PR = 8'h0c;
    localparam logic [SEL_W-1:0] MODE_PT_S = 8'h12;
    localparam logic [SEL_W-1:0] MODE_PR_S = 8'h13;
    localparam logic [SEL_W-1:0] MODE_PT_PR = 8'h14;

    // register map, byte addresses
    localparam logic [AW-1:0] REG_STRIDE = 8'h04;
    localparam logic [AW-1:0] ADDR_DI_SEL = 8'h00;
    localparam logic [AW-1:0] ADDR_DO_SEL = 8'h20;
    localparam logic [AW-1:0] ADDR_MODE = 8'h30;
    localparam logic [AW-1:0] ADDR_ZERO_THR = 8'h34;
    localparam logic [AW-1:0] ADDR_TARGET = 8'h38;
    localparam logic [AW-1:0] ADDR_JOG_SPD = 8'h3c;
    localparam logic [AW-1:0] ADDR_GEAR = 8'h40;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h50;

    // reset values
    localparam logic [SEL_W-1:0] DI_SEL_RST = 8'h00;
    localparam logic [SEL_W-1:0] MODE_RST = 8'h0b;
    localparam logic [SPD_W-1:0] ZERO_THR_RST = 16'h000a;
    localparam logic [SPD_W-1:0] TARGET_RST = 16'h0000;
    localparam logic [SPD_W-1:0] JOG_SPD_RST = 16'h0000;
    localparam logic [SPD_W-1:0] GEAR_RST = 16'h0001;
    localparam logic [DW-1:0] RDATA_IDLE = 32'h0000_0000;
endpackage : io_map_pkg

// ---- di_level_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface di_level_if;
    logic [io_map_pkg::NUM_DI-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface : di_level_if
`default_nettype wire

// ---- di_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module di_sync (
    input  wire logic                        i_ref_clk,
    input  wire logic                        i_reset_n,
    input  wire logic [io_map_pkg::NUM_DI-1:0] i_di_pins,
    di_level_if.src                          sync_out
);
    logic [io_map_pkg::NUM_DI-1:0] meta_r;

    // meta_r feeds only the second stage; pins are asynchronous to the core clock
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            meta_r         <= '0;
            sync_out.level <= '0;
        end
        else
        begin
            meta_r         <= i_di_pins;
            sync_out.level <= meta_r;
        end
    end

    chk_sync_two_stage : assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        $past(i_reset_n, 2) |-> sync_out.level == $past(i_di_pins, 2))
        else $error("input level not delayed by two flops");
endmodule : di_sync
`default_nettype wire

// ---- servo_io_function_map.sv ----
`timescale 1ns/1ps
`default_nettype none
module servo_io_function_map (
    input  wire logic                             i_ref_clk,
    input  wire logic                             i_reset_n,
    input  wire logic [io_map_pkg::AW-1:0]        i_addr,
    input  wire logic [io_map_pkg::DW-1:0]        i_wdata,
    input  wire logic                             i_wr,
    input  wire logic                             i_rd,
    output logic      [io_map_pkg::DW-1:0]        o_rdata,
    input  wire logic [io_map_pkg::NUM_DI-1:0]    i_di_pins,
    input  wire logic                             i_mode_alt,
    input  wire logic                             i_ready_to_run,
    input  wire logic                             i_alarm,
    input  wire logic                             i_ctrl_power,
    input  wire logic [io_map_pkg::SPD_W-1:0]     i_motor_speed,
    output logic      [io_map_pkg::NUM_DO-1:0]    o_do_lines,
    output logic                                  o_jog_fwd,
    output logic                                  o_jog_rev,
    output logic      [io_map_pkg::SPD_W-1:0]     o_jog_speed,
    output logic      [1:0]                       o_gear_sel,
    output logic      [io_map_pkg::SPD_W-1:0]     o_gear_numerator,
    output logic                                  o_pulse_inhibit,
    output logic                                  o_motor_stop,
    output logic                                  o_ext_pulse_mode,
    output logic                                  o_int_pos_mode,
    output logic                                  o_dual_mode
);
    localparam int NDI = io_map_pkg::NUM_DI;
    localparam int NDO = io_map_pkg::NUM_DO;
    localparam int NG  = io_map_pkg::NUM_GEAR;
    localparam int SW  = io_map_pkg::SEL_W;
    localparam int VW  = io_map_pkg::SPD_W;

    di_level_if di_bus ();

    di_sync u_di_sync (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_di_pins (i_di_pins),
        .sync_out  (di_bus.src)
    );

    logic [SW-1:0] di_sel_r  [0:NDI-1];
    logic [SW-1:0] do_sel_r  [0:NDO-1];
    logic [VW-1:0] gear_r    [0:NG-1];
    logic [SW-1:0] mode_r;
    logic [VW-1:0] zero_thr_r;
    logic [VW-1:0] target_r;
    logic [VW-1:0] jog_spd_r;
    logic          stop_prev_r;

    // address decode
    wire [NDI-1:0] di_hit;
    wire [NDO-1:0] do_hit;
    wire [NG-1:0]  gear_hit;
    wire           mode_hit   = (i_addr == io_map_pkg::ADDR_MODE);
    wire           zero_hit   = (i_addr == io_map_pkg::ADDR_ZERO_THR);
    wire           target_hit = (i_addr == io_map_pkg::ADDR_TARGET);
    wire           jog_hit    = (i_addr == io_map_pkg::ADDR_JOG_SPD);
    wire           status_hit = (i_addr == io_map_pkg::ADDR_STATUS);

    // per-line function match; a zero select never matches a function code
    wire [NDI-1:0] m_fwd;
    wire [NDI-1:0] m_rev;
    wire [NDI-1:0] m_g0;
    wire [NDI-1:0] m_g1;
    wire [NDI-1:0] m_inh;
    wire [NDI-1:0] m_stop;
    wire [NDI-1:0] line_enabled;

    function automatic logic [io_map_pkg::AW-1:0] AW8(input int idx);
        AW8 = io_map_pkg::AW'(idx) * io_map_pkg::REG_STRIDE;
    endfunction : AW8

    genvar gi;
    generate
        for (gi = 0; gi < NDI; gi++)
        begin : g_di
            assign di_hit[gi] = (i_addr == io_map_pkg::ADDR_DI_SEL + AW8(gi));
            assign line_enabled[gi] = (di_sel_r[gi] != io_map_pkg::FN_DISABLED) && di_bus.level[gi];
            assign m_fwd[gi]  = line_enabled[gi] && (di_sel_r[gi] == io_map_pkg::FN_JOG_FWD);
            assign m_rev[gi]  = line_enabled[gi] && (di_sel_r[gi] == io_map_pkg::FN_JOG_REV);
            assign m_g0[gi]   = line_enabled[gi] && (di_sel_r[gi] == io_map_pkg::FN_GEAR_SEL0);
            assign m_g1[gi]   = line_enabled[gi] && (di_sel_r[gi] == io_map_pkg::FN_GEAR_SEL1);
            assign m_inh[gi]  = line_enabled[gi] && (di_sel_r[gi] == io_map_pkg::FN_INHIBIT);
            assign m_stop[gi] = line_enabled[gi] && (di_sel_r[gi] == io_map_pkg::FN_STOP);

            always_ff @(posedge i_ref_clk)
            begin
                if (!i_reset_n)
                    di_sel_r[gi] <= io_map_pkg::DI_SEL_RST;
                else if (i_wr && di_hit[gi])
                    di_sel_r[gi] <= i_wdata[SW-1:0];
            end
        end
        for (gi = 0; gi < NDO; gi++)
        begin : g_do
            assign do_hit[gi] = (i_addr == io_map_pkg::ADDR_DO_SEL + AW8(gi));
            always_ff @(posedge i_ref_clk)
            begin
                if (!i_reset_n)
                    do_sel_r[gi] <= SW'(gi + 1);
                else if (i_wr && do_hit[gi])
                    do_sel_r[gi] <= i_wdata[SW-1:0];
            end
        end
        for (gi = 0; gi < NG; gi++)
        begin : g_gear
            assign gear_hit[gi] = (i_addr == io_map_pkg::ADDR_GEAR + AW8(gi));
            always_ff @(posedge i_ref_clk)
            begin
                if (!i_reset_n)
                    gear_r[gi] <= io_map_pkg::GEAR_RST;
                else if (i_wr && gear_hit[gi])
                    gear_r[gi] <= i_wdata[VW-1:0];
            end
        end
    endgenerate

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            mode_r     <= io_map_pkg::MODE_RST;
            zero_thr_r <= io_map_pkg::ZERO_THR_RST;
            target_r   <= io_map_pkg::TARGET_RST;
            jog_spd_r  <= io_map_pkg::JOG_SPD_RST;
        end
        else if (i_wr)
        begin
            if (mode_hit)
                mode_r <= i_wdata[SW-1:0];
            if (zero_hit)
                zero_thr_r <= i_wdata[VW-1:0];
            if (target_hit)
                target_r <= i_wdata[VW-1:0];
            if (jog_hit)
                jog_spd_r <= i_wdata[VW-1:0];
        end
    end

    // mode classification; i_mode_alt only counts in a dual mode
    wire single_mode = (mode_r >= io_map_pkg::MODE_SINGLE_LO) && (mode_r <= io_map_pkg::MODE_SINGLE_HI);
    wire dual_mode   = (mode_r >= io_map_pkg::MODE_DUAL_LO) && (mode_r <= io_map_pkg::MODE_DUAL_HI);
    wire alt_sel     = dual_mode && i_mode_alt;
    wire pt_mode     = (single_mode && (mode_r == io_map_pkg::MODE_PT))
                     || (((mode_r == io_map_pkg::MODE_PT_S) || (mode_r == io_map_pkg::MODE_PT_PR)) && !alt_sel);
    wire pr_mode     = (single_mode && (mode_r == io_map_pkg::MODE_PR))
                     || ((mode_r == io_map_pkg::MODE_PR_S) && !alt_sel)
                     || ((mode_r == io_map_pkg::MODE_PT_PR) && alt_sel);

    // input functions; gear select and inhibit gated by pt_mode, stop by pr_mode, jog in every mode
    wire       fwd_lvl  = |m_fwd;
    wire       rev_lvl  = |m_rev;
    wire [1:0] gsel_nxt = pt_mode ? {|m_g1, |m_g0} : 2'h0;
    wire       inh_nxt  = pt_mode && (|m_inh);
    wire       stop_lvl = pr_mode && (|m_stop);
    wire       stop_nxt = stop_lvl && !stop_prev_r;

    // output functions
    wire ready_st  = i_ready_to_run && !i_alarm;
    wire zero_st   = (i_motor_speed <= zero_thr_r);
    wire target_st = (i_motor_speed >= target_r);
    wire [NDO-1:0] do_nxt;

    generate
        for (gi = 0; gi < NDO; gi++)
        begin : g_do_fn
            assign do_nxt[gi] = ((do_sel_r[gi] == io_map_pkg::FO_READY) && ready_st)
                              || ((do_sel_r[gi] == io_map_pkg::FO_POWER) && i_ctrl_power)
                              || ((do_sel_r[gi] == io_map_pkg::FO_ZERO_SPD) && zero_st)
                              || ((do_sel_r[gi] == io_map_pkg::FO_TARGET_SPD) && target_st);
        end
    endgenerate

    // every level function is recomputed each cycle, so it drops with its input
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            o_jog_fwd        <= 1'b0;
            o_jog_rev        <= 1'b0;
            o_gear_sel       <= 2'h0;
            o_pulse_inhibit  <= 1'b0;
            o_motor_stop     <= 1'b0;
            stop_prev_r      <= 1'b0;
            o_do_lines       <= '0;
            o_ext_pulse_mode <= 1'b0;
            o_int_pos_mode   <= 1'b0;
            o_dual_mode      <= 1'b0;
        end
        else
        begin
            o_jog_fwd        <= fwd_lvl;
            o_jog_rev        <= rev_lvl;
            o_gear_sel       <= gsel_nxt;
            o_pulse_inhibit  <= inh_nxt;
            o_motor_stop     <= stop_nxt;
            stop_prev_r      <= stop_lvl;
            o_do_lines       <= do_nxt;
            o_ext_pulse_mode <= pt_mode;
            o_int_pos_mode   <= pr_mode;
            o_dual_mode      <= dual_mode;
        end
    end

    // speed and numerator follow their selectors; reset loads JOG_SPD_RST and GEAR_RST
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            o_jog_speed      <= io_map_pkg::JOG_SPD_RST;
            o_gear_numerator <= io_map_pkg::GEAR_RST;
        end
        else
        begin
            o_jog_speed      <= jog_spd_r;
            o_gear_numerator <= gear_r[gsel_nxt];
        end
    end

    // read side: data only in the cycle after the strobe, zero otherwise
    logic [io_map_pkg::DW-1:0] rd_nxt;
    wire  [io_map_pkg::DW-1:0] status_word = {
        {(io_map_pkg::DW - NDO - 9){1'b0}}, o_dual_mode, o_int_pos_mode, o_ext_pulse_mode,
        o_do_lines, o_motor_stop, o_pulse_inhibit, o_gear_sel, o_jog_rev, o_jog_fwd};

    always_comb
    begin
        rd_nxt = io_map_pkg::RDATA_IDLE;
        for (int k = 0; k < NDI; k++)
            if (di_hit[k])
                rd_nxt = {{(io_map_pkg::DW - SW){1'b0}}, di_sel_r[k]};
        for (int k = 0; k < NDO; k++)
            if (do_hit[k])
                rd_nxt = {{(io_map_pkg::DW - SW){1'b0}}, do_sel_r[k]};
        for (int k = 0; k < NG; k++)
            if (gear_hit[k])
                rd_nxt = {{(io_map_pkg::DW - VW){1'b0}}, gear_r[k]};
        if (mode_hit)
            rd_nxt = {{(io_map_pkg::DW - SW){1'b0}}, mode_r};
        if (zero_hit)
            rd_nxt = {{(io_map_pkg::DW - VW){1'b0}}, zero_thr_r};
        if (target_hit)
            rd_nxt = {{(io_map_pkg::DW - VW){1'b0}}, target_r};
        if (jog_hit)
            rd_nxt = {{(io_map_pkg::DW - VW){1'b0}}, jog_spd_r};
        if (status_hit)
            rd_nxt = status_word;
        if (!i_rd)
            rd_nxt = io_map_pkg::RDATA_IDLE;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
            o_rdata <= io_map_pkg::RDATA_IDLE;
        else
            o_rdata <= rd_nxt;
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    sequence stop_rise_s;
        !stop_lvl ##1 stop_lvl;
    endsequence

    sequence stop_pulse_s;
        o_motor_stop ##1 !o_motor_stop;
    endsequence

    chk_jog_forward_level : assert property (fwd_lvl |=> o_jog_fwd)
        else $error("forward jog not applied");
    chk_jog_reverse_drop : assert property ($fell(rev_lvl) |=> !o_jog_rev)
        else $error("reverse jog not withdrawn");
    chk_gear_outside_pt : assert property (!pt_mode |=> o_gear_sel == 2'h0)
        else $error("gear select outside pulse mode");
    chk_inhibit_mode_gate : assert property (o_pulse_inhibit |-> $past(pt_mode) && $past(|m_inh))
        else $error("inhibit without pulse mode");
    chk_disabled_line : assert property ((di_sel_r[0] == io_map_pkg::FN_DISABLED)
        |-> !(m_fwd[0] || m_rev[0] || m_g0[0] || m_g1[0] || m_inh[0] || m_stop[0]))
        else $error("disabled input acts");
    chk_mode_classes : assert property (!(single_mode && dual_mode) && (o_dual_mode == $past(dual_mode)))
        else $error("mode class wrong");
    chk_ready_output : assert property ((do_sel_r[0] == io_map_pkg::FO_READY) && i_alarm
        |=> !o_do_lines[0])
        else $error("ready asserted during alarm");
    // sampled reset keeps the release edge out: the lines still hold reset values one cycle longer
    chk_power_output : assert property (i_reset_n && (do_sel_r[1] == io_map_pkg::FO_POWER) && i_ctrl_power
        |=> o_do_lines[1])
        else $error("power output missing");
    chk_zero_speed_out : assert property ((do_sel_r[2] == io_map_pkg::FO_ZERO_SPD)
        && (i_motor_speed > zero_thr_r) |=> !o_do_lines[2])
        else $error("zero speed above threshold");
    chk_target_speed_out : assert property (i_reset_n && (do_sel_r[3] == io_map_pkg::FO_TARGET_SPD)
        && (i_motor_speed >= target_r) |=> o_do_lines[3])
        else $error("target speed missed");
    chk_stop_edge_pulse : assert property (stop_rise_s |=> stop_pulse_s)
        else $error("stop pulse wrong");
    chk_stop_pr_only : assert property (o_motor_stop |-> $past(pr_mode))
        else $error("stop outside internal position mode");
    chk_pt_pr_exclusive : assert property (!(o_ext_pulse_mode && o_int_pos_mode))
        else $error("both position sub-modes");
    chk_read_mode_reg : assert property (i_rd && mode_hit |=> o_rdata[SW-1:0] == $past(mode_r))
        else $error("mode readback wrong");
endmodule : servo_io_function_map
`default_nettype wire

// ---- io_switch_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
// switches on the digital inputs; a level moves only just after a clock edge, like a real controller
module io_switch_bank (
    input  wire logic       i_ref_clk,
    input  wire logic [7:0] i_req,
    output logic      [7:0] o_pins
);
    initial o_pins = 8'h00;
    // the bench keeps pulse inhibit on line index 7, with the same delay as every other line
    always @(posedge i_ref_clk)
    begin
        o_pins <= i_req;
    end
endmodule : io_switch_bank
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        i_ref_clk      = 1'b0;
    logic        i_reset_n      = 1'b0;
    logic [7:0]  i_addr         = 8'h00;
    logic [31:0] i_wdata        = 32'h0;
    logic        i_wr           = 1'b0;
    logic        i_rd           = 1'b0;
    logic        i_mode_alt     = 1'b0;
    logic        i_ready_to_run = 1'b0;
    logic        i_alarm        = 1'b0;
    logic        i_ctrl_power   = 1'b0;
    logic [15:0] i_motor_speed  = 16'h0005;
    logic [7:0]  req            = 8'h00;
    logic [7:0]  pins;
    logic [31:0] o_rdata;
    logic [3:0]  o_do_lines;
    logic [15:0] o_jog_speed;
    logic [15:0] o_gear_numerator;
    logic [1:0]  o_gear_sel;
    logic        o_jog_fwd, o_jog_rev, o_pulse_inhibit, o_motor_stop;
    logic        o_ext_pulse_mode, o_int_pos_mode, o_dual_mode;
    logic        rd_seen        = 1'b0;
    logic [31:0] exp_q[$];
    logic [15:0] gear_v[4];
    int          error_cnt      = 0;
    int          cmp_count      = 0;
    int          stop_cnt       = 0;
    int          seed           = 71344;

    always #12.5 i_ref_clk = ~i_ref_clk;

    io_switch_bank i_io_switch_bank (.i_ref_clk(i_ref_clk), .i_req(req), .o_pins(pins));

    servo_io_function_map i_servo_io_function_map (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_di_pins(pins), .i_mode_alt(i_mode_alt),
        .i_ready_to_run(i_ready_to_run), .i_alarm(i_alarm), .i_ctrl_power(i_ctrl_power),
        .i_motor_speed(i_motor_speed), .o_do_lines(o_do_lines), .o_jog_fwd(o_jog_fwd),
        .o_jog_rev(o_jog_rev), .o_jog_speed(o_jog_speed), .o_gear_sel(o_gear_sel),
        .o_gear_numerator(o_gear_numerator), .o_pulse_inhibit(o_pulse_inhibit),
        .o_motor_stop(o_motor_stop), .o_ext_pulse_mode(o_ext_pulse_mode),
        .o_int_pos_mode(o_int_pos_mode), .o_dual_mode(o_dual_mode));

    task automatic final_report;
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr    <= 1'b0;
    endtask : wr

    // the expected word is queued before the strobe so the monitor always finds it
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd   <= 1'b0;
    endtask : rd

    // pins pass the switch model and two sync flops, so six cycles leave margin
    task automatic press(input logic [7:0] v);
        @(posedge i_ref_clk);
        req <= v;
        repeat (6) @(posedge i_ref_clk);
    endtask : press

    function automatic logic [31:0] st(input logic [2:0] m, input logic [5:0] lo);
        return {19'h0, m, 4'hc, lo};
    endfunction : st

    function automatic logic [2:0] mflags(input int m, input logic alt);
        case (m)
            11: return 3'b001;
            12: return 3'b010;
            18: return alt ? 3'b100 : 3'b101;
            19: return alt ? 3'b100 : 3'b110;
            20: return alt ? 3'b110 : 3'b101;
            default: return 3'b000;
        endcase
    endfunction : mflags

    // read data stand only in the cycle after the strobe
    always @(negedge i_ref_clk)
    begin
        if (rd_seen)
            chk("rdata", o_rdata, exp_q.pop_front());
        rd_seen = i_rd;
    end

    always @(posedge i_ref_clk)
    begin
        if (o_motor_stop === 1'b1)
            stop_cnt++;
    end

    initial
    begin : watchdog
        repeat (20000) @(posedge i_ref_clk);
        error_cnt++;
        final_report();
    end

    initial
    begin : main
        int          k;
        int          a;
        logic [15:0] spd;
        logic [3:0]  v;
        logic [3:0]  dexp;
        logic [7:0]  dsel[4];
        repeat (10) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        for (k = 0; k < 8; k++) rd(8'(4 * k), 32'h0);
        for (k = 0; k < 4; k++) rd(8'(8'h20 + 4 * k), 32'(k + 1));
        for (k = 0; k < 4; k++) rd(8'(8'h40 + 4 * k), 32'h1);
        rd(8'h30, 32'h0b);
        rd(8'h34, 32'h0a);
        rd(8'h38, 32'h0);
        rd(8'h3c, 32'h0);
        rd(8'h60, 32'h0);
        for (a = 0; a < 2; a++)
        begin
            i_mode_alt <= a[0];
            for (k = 10; k < 22; k++)
            begin
                wr(8'h30, 32'hffff_ff00 | 32'(k));
                repeat (3) @(posedge i_ref_clk);
                rd(8'h30, 32'(k));
                rd(8'h50, st(mflags(k, a[0]), 6'h0));
            end
        end
        i_mode_alt <= 1'b0;
        wr(8'h00, 32'h37);
        wr(8'h04, 32'h38);
        wr(8'h08, 32'h43);
        wr(8'h0c, 32'h44);
        wr(8'h10, 32'h46);
        wr(8'h1c, 32'h45);
        for (k = 0; k < 4; k++)
        begin
            gear_v[k] = 16'($random(seed));
            wr(8'(8'h40 + 4 * k), {16'($random(seed)), gear_v[k]});
        end
        wr(8'h3c, 32'h0000_1234);
        repeat (3) @(posedge i_ref_clk);
        chk("jog_speed", 32'(o_jog_speed), 32'h1234);
        wr(8'h30, 32'h0c);
        press(8'h07);
        rd(8'h50, st(3'b010, 6'b000011));
        press(8'h8c);
        rd(8'h50, st(3'b010, 6'b000000));
        stop_cnt = 0;
        press(8'h10);
        press(8'h10);
        chk("stop_pulses", 32'(stop_cnt), 32'd1);
        press(8'h00);
        wr(8'h30, 32'h0b);
        press(8'h10);
        chk("stop_pulses", 32'(stop_cnt), 32'd1);
        press(8'h83);
        rd(8'h50, st(3'b001, 6'b010011));
        for (k = 0; k < 4; k++)
        begin
            press({4'h0, 2'(k), 2'b00});
            rd(8'h50, st(3'b001, {2'b00, 2'(k), 2'b00}));
            chk("gear_numerator", 32'(o_gear_numerator), 32'(gear_v[k]));
        end
        press(8'h00);
        rd(8'h50, st(3'b001, 6'h0));
        wr(8'h34, 32'h0100);
        wr(8'h38, 32'h0200);
        dsel = '{8'h01, 8'h02, 8'h03, 8'h04};
        for (a = 0; a < 2; a++)
        begin
            if (a == 1)
            begin
                dsel = '{8'h04, 8'h03, 8'h02, 8'h00};
                for (k = 0; k < 4; k++) wr(8'(8'h20 + 4 * k), 32'(dsel[k]));
            end
            for (k = 0; k < 24; k++)
            begin
                case (k)
                    0: spd = 16'h0100;
                    1: spd = 16'h0101;
                    2: spd = 16'h01ff;
                    3: spd = 16'h0200;
                    default: spd = 16'($random(seed)) & 16'h03ff;
                endcase
                v = 4'($random(seed));
                @(posedge i_ref_clk);
                i_ready_to_run <= v[0];
                i_alarm        <= v[1];
                i_ctrl_power   <= v[2];
                i_motor_speed  <= spd;
                repeat (2) @(posedge i_ref_clk);
                v = {spd >= 16'h0200, spd <= 16'h0100, v[2], v[0] & ~v[1]};
                for (int l = 0; l < 4; l++)
                    dexp[l] = (dsel[l] >= 8'h01 && dsel[l] <= 8'h04) ? v[dsel[l] - 8'h01] : 1'b0;
                chk("do_lines", 32'(o_do_lines), 32'(dexp));
            end
        end
        repeat (4) @(posedge i_ref_clk);
        final_report();
    end
endmodule : testbench
`default_nettype wire
